// ==== src/rtc_trim_regs.sv ====
// serial-slave register block: test pin, calibration, charge select, halt flag

// Function
// - ft low: test pin follows static level bit
// - ft high: test pin toggles at 512 Hz
// - sign bit 5: 1 speeds up, 0 slows
// - five-bit trim magnitude, 0 to 31
// - adjust pulses at the divide-by-256 stage
// - 64-minute cycle, 62 eligible, one second each
// - negative: blank 128 oscillator cycles per minute
// - positive: insert 256 oscillator cycles per minute
// - magnitude N adjusts first 2N minutes
// - test frequency taken before calibration point
// - control write resets the divider chain
// - charger enabled only for unlock pattern 1010
// - diode field: 01 none, 10 one, else off
// - resistor field: 01/10/11 select, 00 off
// - halt flag set on run-to-stop edge
// - power-up counts as a stop event
// - osc disable stops oscillator, sets halt flag
// - halt flag sticky, cleared only by writing 0
// - flag bits 6..0 read zero, ignore writes
// - other power-up contents need not be forced
// - seconds bit 7 disables oscillator, power-up 0
// - multibyte pointer wraps 07h to 00h
// - 08h explicit only, steps to 09h; 09h wraps to 00h
module rtc_trim_regs #(
    parameter logic [6:0] SLAVE_ADDR = 7'h68
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic osc_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic osc_fail,
    output logic test_pin,
    output rtc_trim_pkg::charge_path_t charge_path,
    output logic second_tick
);
    import rtc_trim_pkg::*;

    // oscillator domain state
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        trim_ctl_t ctl_s1;
        trim_ctl_t ctl_s2;
        logic dr_s1;
        logic dr_s2;
        logic dr_s3;
        logic [7:0] phase;
        logic [SEC_BITS-1:0] sec_cnt;
        logic [5:0] sec_in_min;
        logic [5:0] min_in_cycle;
        logic tick_tgl;
    } osc_state_t;

    // register clock domain state
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic fail_s1;
        logic fail_s2;
        logic tp_s1;
        logic tp_s2;
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
        bus_state_t state;
        byte_kind_t kind;
        logic rw;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [3:0] ptr;
        logic [TIME_REGS-1:0][7:0] time_regs;
        logic [7:0] control;
        logic [7:0] charge;
        logic halt_flag;
        logic run_prev;
        logic dr_tgl;
        trim_ctl_t trim;
        logic sda_o;
        logic sda_oe;
        logic test_pin;
        charge_path_t charge_path;
        logic second_tick;
    } reg_state_t;

    osc_state_t o_q;
    osc_state_t o_d;
    reg_state_t r_q;
    reg_state_t r_d;

    logic adjust_sec;
    logic [SEC_BITS:0] sec_sum;
    logic [1:0] sec_inc;

    always_comb
    begin
        o_d = o_q;
        o_d.rst_s1 = rstn;
        o_d.rst_s2 = o_q.rst_s1;
        o_d.ctl_s1 = r_q.trim;
        // trim word loads in reset, else only once settled behind the restart toggle
        if (!o_q.rst_s2 || (o_q.dr_s2 != o_q.dr_s3))
        begin
            o_d.ctl_s2 = o_q.ctl_s1;
        end
        o_d.dr_s1 = r_q.dr_tgl;
        o_d.dr_s2 = o_q.dr_s1;
        o_d.dr_s3 = o_q.dr_s2;
        // first second of each of the first 2N minutes
        adjust_sec = (o_q.sec_in_min == 6'd0)
            && (o_q.min_in_cycle < ELIGIBLE_MIN)
            && (o_q.min_in_cycle < {o_q.ctl_s2.trim_magnitude, 1'b0});
        sec_inc = 2'd1;
        if (adjust_sec && o_q.ctl_s2.sign
            && ((o_q.phase & 8'(INSERT_SPACING - 1)) == 8'h00))
        begin
            sec_inc = 2'd2;
        end
        else if (adjust_sec && !o_q.ctl_s2.sign
            && ((o_q.phase & 8'(BLANK_SPACING - 1)) == 8'h00))
        begin
            sec_inc = 2'd0;
        end
        sec_sum = {1'b0, o_q.sec_cnt} + {{(SEC_BITS - 1){1'b0}}, sec_inc};
        if (!o_q.rst_s2)
        begin
            o_d.phase = 8'h00;
            o_d.sec_cnt = '0;
            o_d.sec_in_min = 6'd0;
            o_d.min_in_cycle = 6'd0;
            o_d.tick_tgl = 1'b0;
        end
        else if (o_q.dr_s2 != o_q.dr_s3)
        begin
            // divider chain restarts on request from the register side
            o_d.phase = 8'h00;
            o_d.sec_cnt = '0;
        end
        else if (!o_q.ctl_s2.osc_disable)
        begin
            // phase stage feeds the test pin ahead of the trim point
            o_d.phase = o_q.phase + 8'h01;
            // trim acts on the count above the 256 stage
            o_d.sec_cnt = sec_sum[SEC_BITS-1:0];
            if (sec_sum[SEC_BITS])
            begin
                o_d.tick_tgl = !o_q.tick_tgl;
                if (o_q.sec_in_min == SEC_PER_MIN - 6'd1)
                begin
                    o_d.sec_in_min = 6'd0;
                    o_d.min_in_cycle = 6'(o_q.min_in_cycle + 6'd1);
                end
                else
                begin
                    o_d.sec_in_min = o_q.sec_in_min + 6'd1;
                end
            end
        end
    end

    always_ff @(posedge osc_clk)
    begin
        o_q <= o_d;
    end

    // register side
    function automatic logic [7:0] read_reg(input reg_state_t s);
        logic [7:0] v;
        v = 8'h00;
        if (s.ptr <= ADDR_YEAR)
        begin
            v = s.time_regs[s.ptr[2:0]];
        end
        else if (s.ptr == ADDR_CONTROL)
        begin
            v = s.control;
        end
        else if (s.ptr == ADDR_CHARGE)
        begin
            v = s.charge;
        end
        else if (s.ptr == ADDR_FLAG)
        begin
            v = {s.halt_flag, 7'h00};
        end
        return v;
    endfunction

    function automatic logic [3:0] next_ptr(input logic [3:0] p);
        logic [3:0] n;
        n = p + 4'h1;
        if (p == ADDR_CONTROL || p >= ADDR_FLAG)
        begin
            n = ADDR_SECONDS;
        end
        return n;
    endfunction

    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic osc_run;
    logic halt_set;
    logic halt_clr;
    logic [7:0] rd_byte;

    always_comb
    begin
        r_d = r_q;
        r_d.scl_s1 = scl_i;
        r_d.scl_s2 = r_q.scl_s1;
        r_d.scl_p = r_q.scl_s2;
        r_d.sda_s1 = sda_i;
        r_d.sda_s2 = r_q.sda_s1;
        r_d.sda_p = r_q.sda_s2;
        r_d.fail_s1 = osc_fail;
        r_d.fail_s2 = r_q.fail_s1;
        r_d.tp_s1 = o_q.phase[TEST_BIT];
        r_d.tp_s2 = r_q.tp_s1;
        r_d.tick_s1 = o_q.tick_tgl;
        r_d.tick_s2 = r_q.tick_s1;
        r_d.tick_s3 = r_q.tick_s2;
        r_d.sda_o = 1'b0;
        start_seen = r_q.scl_s2 && r_q.scl_p && r_q.sda_p && !r_q.sda_s2;
        stop_seen = r_q.scl_s2 && r_q.scl_p && !r_q.sda_p && r_q.sda_s2;
        scl_rise = r_q.scl_s2 && !r_q.scl_p;
        scl_fall = !r_q.scl_s2 && r_q.scl_p;
        halt_clr = 1'b0;
        rd_byte = read_reg(r_q);

        if (start_seen)
        begin
            r_d.state = BUS_RX;
            r_d.kind = BYTE_ADDR;
            r_d.bitcnt = 4'd0;
            r_d.sda_oe = 1'b0;
        end
        else if (stop_seen)
        begin
            r_d.state = BUS_IDLE;
            r_d.sda_oe = 1'b0;
        end
        else
        begin
            unique case (r_q.state)
                BUS_IDLE:
                begin
                    r_d.sda_oe = 1'b0;
                end
                BUS_RX:
                begin
                    if (scl_rise)
                    begin
                        r_d.shift = {r_q.shift[6:0], r_q.sda_s2};
                        r_d.bitcnt = r_q.bitcnt + 4'd1;
                    end
                    else if (scl_fall && r_q.bitcnt == BITS_PER_BYTE)
                    begin
                        r_d.state = BUS_ACK;
                        r_d.sda_oe = 1'b1;
                        unique case (r_q.kind)
                            BYTE_ADDR:
                            begin
                                r_d.rw = r_q.shift[0];
                                if (r_q.shift[7:1] != SLAVE_ADDR)
                                begin
                                    r_d.state = BUS_IDLE;
                                    r_d.sda_oe = 1'b0;
                                end
                            end
                            BYTE_PTR:
                            begin
                                r_d.ptr = r_q.shift[3:0];
                            end
                            BYTE_DATA:
                            begin
                                // write lands on the acknowledge
                                if (r_q.ptr <= ADDR_YEAR)
                                begin
                                    r_d.time_regs[r_q.ptr[2:0]] = r_q.shift;
                                end
                                if (r_q.ptr == ADDR_SECONDS)
                                begin
                                    r_d.dr_tgl = !r_q.dr_tgl;
                                end
                                if (r_q.ptr == ADDR_CONTROL)
                                begin
                                    r_d.control = r_q.shift;
                                    r_d.dr_tgl = !r_q.dr_tgl;
                                end
                                if (r_q.ptr == ADDR_CHARGE)
                                begin
                                    r_d.charge = r_q.shift;
                                end
                                if (r_q.ptr == ADDR_FLAG)
                                begin
                                    // only a zero clears; low bits dropped
                                    halt_clr = !r_q.shift[HALT_FLAG_BIT];
                                end
                                r_d.ptr = next_ptr(r_q.ptr);
                            end
                            default:
                            begin
                                r_d.state = BUS_IDLE;
                                r_d.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
                BUS_ACK:
                begin
                    if (scl_fall)
                    begin
                        r_d.bitcnt = 4'd0;
                        if (r_q.kind == BYTE_ADDR && r_q.rw)
                        begin
                            r_d.state = BUS_TX;
                            r_d.shift = rd_byte;
                            r_d.sda_oe = !rd_byte[7];
                            r_d.ptr = next_ptr(r_q.ptr);
                        end
                        else
                        begin
                            r_d.state = BUS_RX;
                            r_d.sda_oe = 1'b0;
                            r_d.kind = (r_q.kind == BYTE_ADDR) ? BYTE_PTR
                                                                : BYTE_DATA;
                        end
                    end
                end
                BUS_TX:
                begin
                    if (scl_rise)
                    begin
                        r_d.shift = {r_q.shift[6:0], 1'b0};
                        r_d.bitcnt = r_q.bitcnt + 4'd1;
                    end
                    else if (scl_fall)
                    begin
                        if (r_q.bitcnt == BITS_PER_BYTE)
                        begin
                            r_d.state = BUS_MACK;
                            r_d.sda_oe = 1'b0;
                        end
                        else
                        begin
                            r_d.sda_oe = !r_q.shift[7];
                        end
                    end
                end
                BUS_MACK:
                begin
                    if (scl_rise && r_q.sda_s2)
                    begin
                        r_d.state = BUS_IDLE; // not acknowledged: read ends
                    end
                    else if (scl_fall)
                    begin
                        r_d.state = BUS_TX;
                        r_d.bitcnt = 4'd0;
                        r_d.shift = rd_byte;
                        r_d.sda_oe = !rd_byte[7];
                        r_d.ptr = next_ptr(r_q.ptr);
                    end
                end
                default:
                begin
                    r_d.state = BUS_IDLE;
                    r_d.sda_oe = 1'b0;
                end
            endcase
        end

        // oscillator stop detection, set wins over clear
        osc_run = !r_q.time_regs[ADDR_SECONDS[2:0]][OSC_DISABLE_BIT]
            && !r_q.fail_s2;
        halt_set = r_q.run_prev && !osc_run;
        r_d.run_prev = osc_run;
        r_d.halt_flag = halt_set || (r_q.halt_flag && !halt_clr);

        // quasi-static controls handed to the oscillator side
        r_d.trim.sign = r_q.control[CTL_SIGN_BIT];
        r_d.trim.trim_magnitude = r_q.control[CTL_MAG_MSB:0];
        r_d.trim.osc_disable =
            r_q.time_regs[ADDR_SECONDS[2:0]][OSC_DISABLE_BIT];

        if (r_q.control[CTL_FT_BIT])
        begin
            r_d.test_pin = r_q.tp_s2;
        end
        else
        begin
            r_d.test_pin = r_q.control[CTL_OUT_BIT];
        end

        r_d.charge_path.enable = (r_q.charge[7:4] == CHARGE_UNLOCK_CODE)
            && (r_q.charge[3:2] == DIODE_NONE
                || r_q.charge[3:2] == DIODE_ONE)
            && (r_q.charge[1:0] != RESISTOR_OFF);
        r_d.charge_path.diode_on = r_d.charge_path.enable
            && (r_q.charge[3:2] == DIODE_ONE);
        r_d.charge_path.resistor_pick = r_d.charge_path.enable
            ? r_q.charge[1:0] : RESISTOR_OFF;

        r_d.second_tick = r_q.tick_s2 != r_q.tick_s3;

        if (!rstn)
        begin
            r_d.state = BUS_IDLE;
            r_d.kind = BYTE_ADDR;
            r_d.rw = 1'b0;
            r_d.bitcnt = 4'd0;
            r_d.shift = 8'h00;
            r_d.ptr = ADDR_SECONDS;
            // timekeeping bytes cleared for determinism only
            r_d.time_regs = {TIME_REGS{TIME_RESET}};
            r_d.control = CONTROL_RESET;
            r_d.charge = CHARGE_RESET;
            r_d.halt_flag = 1'b1;
            r_d.run_prev = 1'b0;
            r_d.dr_tgl = 1'b0;
            r_d.trim = '0;
            r_d.sda_o = 1'b0;
            r_d.sda_oe = 1'b0;
            r_d.test_pin = 1'b1;
            r_d.charge_path = '0;
            r_d.second_tick = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        r_q <= r_d;
    end

    assign sda_o = r_q.sda_o;
    assign sda_oe = r_q.sda_oe;
    assign test_pin = r_q.test_pin;
    assign charge_path = r_q.charge_path;
    assign second_tick = r_q.second_tick;

endmodule

// ==== src/rtc_trim_pkg.sv ====
// constants and carriers for the rtc trim, charge and flag register block
package rtc_trim_pkg;

    // register locations on the serial register pointer
    localparam logic [3:0] ADDR_SECONDS = 4'h0;
    localparam logic [3:0] ADDR_YEAR = 4'h6;
    localparam logic [3:0] ADDR_CONTROL = 4'h7;
    localparam logic [3:0] ADDR_CHARGE = 4'h8;
    localparam logic [3:0] ADDR_FLAG = 4'h9;
    localparam int TIME_REGS = 7;

    // field positions
    localparam int OSC_DISABLE_BIT = 7;
    localparam int CTL_OUT_BIT = 7;
    localparam int CTL_FT_BIT = 6;
    localparam int CTL_SIGN_BIT = 5;
    localparam int CTL_MAG_MSB = 4;
    localparam int HALT_FLAG_BIT = 7;

    // power-up values
    localparam logic [7:0] TIME_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h80;
    localparam logic [7:0] CHARGE_RESET = 8'h00;

    // charge select codes
    localparam logic [3:0] CHARGE_UNLOCK_CODE = 4'ha;
    localparam logic [1:0] DIODE_NONE = 2'b01;
    localparam logic [1:0] DIODE_ONE = 2'b10;
    localparam logic [1:0] RESISTOR_OFF = 2'b00;

    // oscillator timebase and calibration figures
    localparam int OSC_HZ = 32768;
    localparam int TEST_HZ = 512;
    localparam int TEST_BIT = $clog2(OSC_HZ / (2 * TEST_HZ));
    localparam int DIV_STAGE = 256;
    localparam int BLANK_CYCLES = 128;
    localparam int INSERT_CYCLES = 256;
    localparam int BLANK_SPACING = OSC_HZ / BLANK_CYCLES;
    localparam int INSERT_SPACING = OSC_HZ / INSERT_CYCLES;
    localparam int SEC_BITS = $clog2(OSC_HZ);
    localparam logic [5:0] SEC_PER_MIN = 6'd60;
    localparam int MIN_PER_CYCLE = 64;
    localparam logic [5:0] ELIGIBLE_MIN = 6'd62;

    // serial slave
    localparam logic [3:0] BITS_PER_BYTE = 4'd8;

    typedef enum logic [4:0] {
        BUS_IDLE = 5'b00001,
        BUS_RX = 5'b00010,
        BUS_ACK = 5'b00100,
        BUS_TX = 5'b01000,
        BUS_MACK = 5'b10000
    } bus_state_t;

    typedef enum logic [1:0] {
        BYTE_ADDR = 2'd0,
        BYTE_PTR = 2'd1,
        BYTE_DATA = 2'd2
    } byte_kind_t;

    typedef struct packed {
        logic enable;
        logic diode_on;
        logic [1:0] resistor_pick;
    } charge_path_t;

    typedef struct packed {
        logic sign;
        logic [4:0] trim_magnitude;
        logic osc_disable;
    } trim_ctl_t;

endpackage

// ==== sim/rtc_trim_regs_sva.sv ====
// pin assertions for the rtc trim register block
module rtc_trim_regs_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic test_pin,
    input wire rtc_trim_pkg::charge_path_t charge_path,
    input wire logic second_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_trim_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_oe_rise_low: assert property (
        $rose(sda_oe) |-> !$past(scl_i) && !scl_i)
        else $error("sda pulled while scl high");
    a_oe_fall_low: assert property (
        $fell(sda_oe) |-> !$past(scl_i) && !scl_i)
        else $error("sda released while scl high");
    a_oe_holds_high: assert property (
        scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("sda drive moved during scl high");
    a_drain_only: assert property (
        sda_oe |-> sda_o == 1'b0)
        else $error("sda driven high");
    a_charge_off: assert property (
        !charge_path.enable |-> charge_path == 4'h0)
        else $error("charge select not cleared when off");
    a_charge_res: assert property (
        charge_path.enable |-> charge_path.resistor_pick != RESISTOR_OFF)
        else $error("charger on without resistor");
    a_charge_on_write: assert property (
        $changed(charge_path) |-> !$past(scl_i))
        else $error("charge select moved outside a write");
    a_tick_one: assert property (
        second_tick |=> !second_tick [*8])
        else $error("second tick too long");

    cover property (charge_path.enable);
    cover property ($rose(second_tick));
    cover property ($changed(test_pin));
    cover property ($rose(sda_oe));
endmodule

bind rtc_trim_regs rtc_trim_regs_sva u_sva (.clk(clk), .rstn(rstn),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .test_pin(test_pin),
    .charge_path(charge_path), .second_tick(second_tick));

// ==== sim/serial_master.sv ====
// two-wire bus master model: open-drain data, master-owned clock
module serial_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    output logic res_valid,
    output logic [7:0] res
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        res_valid = 1'b0;
        res = 8'h00;
    end

    // data moves mid-low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        repeat (4) @(posedge clk);
        sda_low <= ~b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (7) @(posedge clk);
        s = sda;
        @(posedge clk);
        scl <= 1'b0;
    endtask

    // sda_low moves from a to b while scl is high
    task automatic cond(input logic a, input logic b);
        repeat (4) @(posedge clk);
        sda_low <= a;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (8) @(posedge clk);
        sda_low <= b;
        repeat (8) @(posedge clk);
    endtask

    task automatic bus_start;
        cond(1'b0, 1'b1);
        scl <= 1'b0;
    endtask

    task automatic bus_stop;
        cond(1'b1, 1'b0);
    endtask

    task automatic put(input logic [7:0] v);
        res <= v;
        res_valid <= 1'b1;
        @(posedge clk);
        res_valid <= 1'b0;
    endtask

    // reports the acknowledge level as the result
    task automatic wr(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        put({7'h00, s});
    endtask

    task automatic rd(input logic last);
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
        put(d);
    endtask
endmodule

// ==== sim/rtc_trim_regs_bench.sv ====
// self-checking bench for the rtc trim register block
module rtc_trim_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_trim_pkg::*;
    localparam logic [6:0] DEV = 7'h68;
    localparam int HALF_CLK = 32768 / 1024 * 15 / 10;
    localparam int CAL_OSC = 32768 - 256;
    logic clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rstn = 1'b0;
    logic osc_fail = 1'b0;
    wire scl;
    wire sda_low;
    wire sda;
    wire res_valid;
    wire [7:0] res;
    logic sda_o;
    logic sda_oe;
    logic test_pin;
    charge_path_t charge_path;
    logic second_tick;
    logic [7:0] exp_q[$];
    logic [7:0] d;
    int n;
    int t0;
    int osc_n = 0;
    int failures = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;
    initial
    begin
        #2.3;
        forever #7.5 osc_clk = ~osc_clk;
    end
    always @(posedge osc_clk) osc_n++;

    // wired-and data line with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_o));

    rtc_trim_regs #(.SLAVE_ADDR(DEV)) dut (.clk(clk), .rstn(rstn),
        .osc_clk(osc_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .osc_fail(osc_fail), .test_pin(test_pin),
        .charge_path(charge_path), .second_tick(second_tick));
    serial_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low),
        .res_valid(res_valid), .res(res));

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        cmp_count++;
        if (got !== want)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                want);
        end
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [3:0] charge_exp(input logic [7:0] v);
        logic on;
        on = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2);
        on = on && v[1:0] != 2'h0;
        return on ? {1'b1, v[3:2] == 2'h2, v[1:0]} : 4'h0;
    endfunction

    task automatic reg_wr(input logic [3:0] ptr, input logic [7:0] v[$]);
        repeat (v.size() + 2) exp_q.push_back(8'h00);
        m.bus_start();
        m.wr({DEV, 1'b0});
        m.wr({4'h0, ptr});
        foreach (v[i])
            m.wr(v[i]);
        m.bus_stop();
    endtask

    task automatic reg_rd(input logic [3:0] ptr, input logic [7:0] v[$]);
        repeat (3) exp_q.push_back(8'h00);
        foreach (v[i])
            exp_q.push_back(v[i]);
        m.bus_start();
        m.wr({DEV, 1'b0});
        m.wr({4'h0, ptr});
        m.bus_start();
        m.wr({DEV, 1'b1});
        foreach (v[i])
            m.rd(i == v.size() - 1);
        m.bus_stop();
    endtask

    // clk cycles of one full level of the test pin
    task automatic half_period(output int cnt);
        logic w;
        repeat (2)
        begin
            w = test_pin;
            cnt = 0;
            while (test_pin === w && cnt < 200)
            begin
                @(posedge clk);
                #1;
                cnt++;
            end
        end
    endtask

    // each result from the master meets the oldest expectation
    always @(posedge clk)
    begin
        if (res_valid === 1'b1)
        begin
            if (exp_q.size() > 0)
                check(res, exp_q.pop_front());
            else
                check(res, 8'hxx);
        end
    end

    initial
    begin
        // about 95k clk; the tests need near 72k
        #950000;
        failures++;
        $display("watchdog expired at %0t", $time);
        test_done();
    end

    initial
    begin
        void'($urandom(39));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        check({7'h00, test_pin}, 8'h01);
        check({4'h0, charge_path}, 8'h00);
        reg_rd(ADDR_CONTROL, '{8'h80});
        reg_rd(ADDR_CHARGE, '{8'h00});
        reg_rd(ADDR_FLAG, '{8'h80});
        exp_q.push_back(8'h01);
        m.bus_start();
        m.wr({~DEV, 1'b0});
        m.bus_stop();
        $display("test power_up done");

        reg_wr(ADDR_FLAG, '{8'hff});
        reg_rd(ADDR_FLAG, '{8'h80});
        reg_wr(ADDR_FLAG, '{8'h7f});
        reg_rd(ADDR_FLAG, '{8'h00});
        reg_wr(ADDR_FLAG, '{8'hff});
        reg_rd(ADDR_FLAG, '{8'h00});
        reg_wr(ADDR_SECONDS, '{8'h80});
        reg_rd(ADDR_SECONDS, '{8'h80});
        reg_rd(ADDR_FLAG, '{8'h80});
        reg_wr(ADDR_SECONDS, '{8'h00});
        reg_wr(ADDR_FLAG, '{8'h00});
        osc_fail <= 1'b1;
        repeat (8) @(posedge clk);
        osc_fail <= 1'b0;
        reg_rd(ADDR_FLAG, '{8'h80});
        $display("test halt_flag done");

        reg_wr(ADDR_CONTROL, '{8'h80, 8'h15});
        reg_rd(ADDR_CONTROL, '{8'h80, 8'h15});
        reg_wr(ADDR_FLAG, '{8'h00, 8'h27});
        reg_rd(ADDR_CHARGE, '{8'h00, 8'h00, 8'h27});
        $display("test pointer_wrap done");

        // no supply model here, so low resistor codes are harmless
        for (int i = 0; i < 20; i++)
        begin
            d = (i < 16) ? {4'ha, 4'(i)} : 8'($urandom);
            reg_wr(ADDR_CHARGE, '{d});
            check({4'h0, charge_path}, {4'h0, charge_exp(d)});
        end
        reg_rd(ADDR_CHARGE, '{d});
        $display("test charge done");

        reg_wr(ADDR_CONTROL, '{8'h00});
        check({7'h00, test_pin}, 8'h00);
        d = {2'h1, 1'($urandom), 5'(1 + $urandom % 31)};
        reg_wr(ADDR_CONTROL, '{d});
        half_period(n);
        check(8'(n >= HALF_CLK - 2 && n <= HALF_CLK + 2), 8'h01);
        $display("test test_pin done");

        // first second of minute 0 after the divider restart is trimmed
        d = {3'h1, 5'(1 + $urandom % 31)};
        reg_wr(ADDR_CONTROL, '{d});
        t0 = osc_n;
        n = 0;
        while (second_tick !== 1'b1 && n < 60000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        n = osc_n - t0;
        check(8'(n >= CAL_OSC - 40 && n <= CAL_OSC + 8), 8'h01);
        $display("test calibration done");
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule
